// ### scf_formatter.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: Raw mode 0 passes every captured bit unchanged, in arrival order.
// R2: Three-bit mode selects six capture modes 0-5 and test modes 6, 7.
// R3: First bit in time becomes the word's most significant bit.
// R4: Aligned mode 1 widens each 10-bit group to a 16-bit word.
// R5: Aligned word: group in 9:0, new-alignment flag bit 10, zeros 15:12.
// R6: Decoded mode 2 decodes 8b/10b into a byte inside a 16-bit word.
// R7: Decoded word: byte 7:0, control bit 8, errors 9-10, valid 11, zeros above.
// R8: Data mode 3 forwards only error-free data bytes, drops control and errors.
// R9: Mode 4 outputs whole TS frames; drop-null bit 4 removes idle packets except their sync and three header bytes.
// R10: Mode 5 outputs TS frames, always drops idle packets after their sync and three header bytes; timestamp undefined.
// R11: Mode 6 replaces capture with PRBS15 pattern bits to the output.
// R12: Mode 7 is reserved and produces no output.
// R13: Recognise 188-byte packets starting with sync byte 0x47 and three headers.
// R14: Header bits: error, unit start, 13-bit PID, scramble, adaptation, counter.
// R15: Also accept 204-byte packets carrying extra check bytes.
// R16: Mute disables capture on the channel.
// R17: New-alignment flag only on the first word after realignment.
// R18: PRBS15 uses x^15+x^14+1, nonzero seed, one bit per bit time.
module scf_formatter
#(
  parameter int OUT_W = 16
)
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [2:0]       mode,
  input  wire logic             cfg_drop_null,
  input  wire logic             mute,
  input  wire logic             bit_in,
  input  wire logic             bit_valid,
  input  wire logic             realign,
  output logic [OUT_W-1:0]      dma_word,
  output logic                  dma_valid,
  output logic                  ts_locked,
  output logic                  ts_long,
  output logic                  hdr_tei,
  output logic                  hdr_pusi,
  output logic [12:0]           hdr_pid,
  output logic [1:0]            hdr_scramble,
  output logic [1:0]            hdr_adapt,
  output logic [3:0]            hdr_cc
);
  logic [9:0]       sh_r;
  logic [3:0]       cnt_r;
  logic [4:0]       raw_cnt_r;
  logic [OUT_W-1:0] raw_sh_r;
  logic             newal_r;
  logic [14:0]      prbs_r;
  logic [2:0]       bcnt_r;
  logic [7:0]       tsb_r;
  logic [7:0]       pos_r;
  logic [23:0]      hdr_r;
  logic             drop_r;
  logic [7:0]       dec_byte;
  logic             dec_ctrl;
  logic             dec_cerr;
  logic             dec_derr;
  logic             take;
  logic             grp_done;
  logic [9:0]       grp;
  logic             src_bit;
  logic             byte_done;
  logic [7:0]       byte_val;
  logic             drop_now;
  logic             sync_hit;
  logic             next_sync;
  logic             ts_keep;

  // Mute gates capture entirely, including the test pattern
  assign take     = bit_valid & ~mute; // R16
  assign src_bit  = (mode == scf_pkg::MODE_PRBS) ? prbs_r[14] : bit_in; // R11
  assign grp      = {sh_r[8:0], bit_in}; // R3
  assign grp_done = take && (cnt_r == 4'd9);
  assign byte_val = {tsb_r[6:0], bit_in}; // R3
  assign byte_done = take && (bcnt_r == 3'd7);

  scf_dec8b10b u_dec
  (
    .group    (grp),
    .byte_out (dec_byte),
    .is_ctrl  (dec_ctrl),
    .code_err (dec_cerr),
    .disp_err (dec_derr)
  );

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prbs_r <= scf_pkg::PRBS_SEED;
    end
    else if (take)
    begin
      prbs_r <= {prbs_r[13:0], prbs_r[14] ^ prbs_r[13]}; // R18
    end
  end

  // Group boundary; realign restarts the 10-bit count
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sh_r    <= 10'h000;
      cnt_r   <= scf_pkg::CNT_RST;
      newal_r <= 1'b0;
    end
    else
    begin
      if (realign)
      begin
        cnt_r   <= scf_pkg::CNT_RST;
        newal_r <= 1'b1; // R17
      end
      else if (take)
      begin
        sh_r  <= grp;
        cnt_r <= (cnt_r == 4'd9) ? 4'd0 : cnt_r + 4'd1;
        if (grp_done && mode == scf_pkg::MODE_ALIGNED)
        begin
          newal_r <= 1'b0; // R17
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      raw_sh_r  <= scf_pkg::WORD_RST;
      raw_cnt_r <= 5'h00;
    end
    else if (realign)
    begin
      raw_cnt_r <= 5'h00;
    end
    else if (take)
    begin
      raw_sh_r  <= {raw_sh_r[OUT_W-2:0], src_bit}; // R1
      raw_cnt_r <= (raw_cnt_r == 5'(OUT_W - 1)) ? 5'h00 : raw_cnt_r + 5'h01;
    end
  end

  // TS byte framer: hunt for sync at any bit, then count bytes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tsb_r     <= 8'h00;
      bcnt_r    <= 3'h0;
      pos_r     <= 8'h00;
      ts_locked <= 1'b0;
      ts_long   <= 1'b0;
      hdr_r     <= 24'h00_0000;
      drop_r    <= 1'b0;
    end
    else if (realign)
    begin
      // Stale lock from another mode would skew the first packet
      ts_locked <= 1'b0;
      ts_long   <= 1'b0;
      bcnt_r    <= 3'h0;
      pos_r     <= 8'h00;
    end
    else if (take)
    begin
      tsb_r <= byte_val;
      if (!ts_locked)
      begin
        if (byte_val == scf_pkg::TS_SYNC) // R13
        begin
          ts_locked <= 1'b1;
          bcnt_r    <= 3'h0;
          pos_r     <= 8'h01;
          ts_long   <= 1'b0;
        end
      end
      else
      begin
        bcnt_r <= bcnt_r + 3'h1;
        if (byte_done)
        begin
          if (pos_r >= 8'd1 && pos_r <= 8'd3)
          begin
            hdr_r <= {hdr_r[15:0], byte_val}; // R14
          end
          if (pos_r == 8'd3)
          begin
            drop_r <= ({hdr_r[12:0], byte_val[7:0]} >> 8) == 21'(scf_pkg::TS_NULL_PID);
          end
          if (pos_r == scf_pkg::TS_LEN_STD && !ts_long)
          begin
            if (byte_val == scf_pkg::TS_SYNC)
            begin
              pos_r <= 8'h01;
            end
            else
            begin
              ts_long <= 1'b1; // R15
              pos_r   <= pos_r + 8'h01;
            end
          end
          else if (pos_r == scf_pkg::TS_LEN_FEC)
          begin
            pos_r     <= 8'h01;
            ts_locked <= (byte_val == scf_pkg::TS_SYNC);
            ts_long   <= 1'b0;
          end
          else
          begin
            pos_r <= pos_r + 8'h01;
          end
        end
      end
    end
  end

  assign hdr_tei      = hdr_r[23];
  assign hdr_pusi     = hdr_r[22];
  assign hdr_pid      = hdr_r[20:8];
  assign hdr_scramble = hdr_r[7:6];
  assign hdr_adapt    = hdr_r[5:4];
  assign hdr_cc       = hdr_r[3:0];

  // Early header bytes emit before the PID is known; null test uses the stored flag
  assign drop_now = (mode == scf_pkg::MODE_TS_TIME) || (cfg_drop_null && mode == scf_pkg::MODE_TS); // R9 R10
  // Locking byte is itself the sync and must reach the output
  assign sync_hit  = take && !ts_locked && (byte_val == scf_pkg::TS_SYNC); // R13
  // Sync opening the next packet survives a dropped idle packet
  assign next_sync = (byte_val == scf_pkg::TS_SYNC) &&
                     (pos_r == scf_pkg::TS_LEN_FEC || (pos_r == scf_pkg::TS_LEN_STD && !ts_long)); // R15
  assign ts_keep   = byte_done && ts_locked && !(drop_now && drop_r && pos_r > 8'd3 && !next_sync); // R9 R10

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dma_word  <= scf_pkg::WORD_RST;
      dma_valid <= 1'b0;
    end
    else
    begin
      dma_valid <= 1'b0;
      case (mode) // R2
        scf_pkg::MODE_RAW, scf_pkg::MODE_PRBS:
        begin
          if (take && !realign && raw_cnt_r == 5'(OUT_W - 1))
          begin
            dma_word  <= {raw_sh_r[OUT_W-2:0], src_bit}; // R1 R11
            dma_valid <= 1'b1;
          end
        end
        scf_pkg::MODE_ALIGNED:
        begin
          if (grp_done && !realign)
          begin
            dma_word  <= {4'h0, 1'b0, newal_r, grp}; // R4 R5
            dma_valid <= 1'b1;
          end
        end
        scf_pkg::MODE_DECODED:
        begin
          if (grp_done && !realign)
          begin
            dma_word  <= {4'h0, ~(dec_cerr | dec_derr), dec_cerr, dec_derr, dec_ctrl, dec_byte}; // R6 R7
            dma_valid <= 1'b1;
          end
        end
        scf_pkg::MODE_DATA:
        begin
          if (grp_done && !realign && !dec_ctrl && !dec_cerr && !dec_derr) // R8
          begin
            dma_word  <= {8'h00, dec_byte};
            dma_valid <= 1'b1;
          end
        end
        scf_pkg::MODE_TS, scf_pkg::MODE_TS_TIME:
        begin
          if (!realign && (sync_hit || ts_keep)) // R9 R10 R13
          begin
            dma_word  <= {8'h00, byte_val};
            dma_valid <= 1'b1;
          end
        end
        default: dma_valid <= 1'b0; // R12
      endcase
    end
  end
endmodule // scf_formatter
`default_nettype wire

// ### scf_pkg.sv
package scf_pkg;
  localparam logic [2:0] MODE_RAW     = 3'h0;
  localparam logic [2:0] MODE_ALIGNED = 3'h1;
  localparam logic [2:0] MODE_DECODED = 3'h2;
  localparam logic [2:0] MODE_DATA    = 3'h3;
  localparam logic [2:0] MODE_TS      = 3'h4;
  localparam logic [2:0] MODE_TS_TIME = 3'h5;
  localparam logic [2:0] MODE_PRBS    = 3'h6;
  localparam logic [2:0] MODE_RSVD    = 3'h7;
  localparam int           GROUP_BITS   = 10;
  localparam int           WORD_BITS    = 16;
  localparam int           POS_DATA_LSB = 0;
  localparam int           POS_NEWALIGN = 10;
  localparam int           POS_CTRL     = 8;
  localparam int           POS_DISP_ERR = 9;
  localparam int           POS_CODE_ERR = 10;
  localparam int           POS_VALID    = 11;
  localparam int           CFG_DROP_NULL = 4;
  localparam logic [7:0]  TS_SYNC      = 8'h47;
  localparam logic [7:0]  TS_LEN_STD   = 8'hBC;
  localparam logic [7:0]  TS_LEN_FEC   = 8'hCC;
  localparam logic [12:0] TS_NULL_PID  = 13'h1FFF;
  localparam logic [14:0] PRBS_SEED    = 15'h7FFF;
  localparam logic [3:0]  CNT_RST      = 4'h0;
  localparam logic [15:0] WORD_RST     = 16'h0000;
endpackage : scf_pkg

// ### scf_dec8b10b.sv
`timescale 1ns/10ps
`default_nettype none
// Combinational 8b/10b decoder; group bit 9 is the first bit received (a)
module scf_dec8b10b
(
  input  wire logic [9:0] group,
  output logic      [7:0] byte_out,
  output logic            is_ctrl,
  output logic            code_err,
  output logic            disp_err
);
  logic [5:0] six;
  logic [3:0] four;
  logic [4:0] edc;
  logic [2:0] fgh;
  logic       e6_bad;
  logic       e4_bad;
  int         ones;

  always_comb
  begin
    six    = group[9:4];
    four   = group[3:0];
    edc    = 5'h00;
    fgh    = 3'h0;
    e6_bad = 1'b0;
    e4_bad = 1'b0;
    is_ctrl = 1'b0;
    ones   = 0;
    case (six) // R6
      6'b100111, 6'b011000: edc = 5'd0;
      6'b011101, 6'b100010: edc = 5'd1;
      6'b101101, 6'b010010: edc = 5'd2;
      6'b110001:            edc = 5'd3;
      6'b110101, 6'b001010: edc = 5'd4;
      6'b101001:            edc = 5'd5;
      6'b011001:            edc = 5'd6;
      6'b111000, 6'b000111: edc = 5'd7;
      6'b111001, 6'b000110: edc = 5'd8;
      6'b100101:            edc = 5'd9;
      6'b010101:            edc = 5'd10;
      6'b110100:            edc = 5'd11;
      6'b001101:            edc = 5'd12;
      6'b101100:            edc = 5'd13;
      6'b011100:            edc = 5'd14;
      6'b010111, 6'b101000: edc = 5'd15;
      6'b011011, 6'b100100: edc = 5'd16;
      6'b100011:            edc = 5'd17;
      6'b010011:            edc = 5'd18;
      6'b110010:            edc = 5'd19;
      6'b001011:            edc = 5'd20;
      6'b101010:            edc = 5'd21;
      6'b011010:            edc = 5'd22;
      6'b111010, 6'b000101: edc = 5'd23;
      6'b110011, 6'b001100: edc = 5'd24;
      6'b100110:            edc = 5'd25;
      6'b010110:            edc = 5'd26;
      6'b110110, 6'b001001: edc = 5'd27;
      6'b001110:            edc = 5'd28;
      6'b101110, 6'b010001: edc = 5'd29;
      6'b011110, 6'b100001: edc = 5'd30;
      6'b101011, 6'b010100: edc = 5'd31;
      6'b001111, 6'b110000:
      begin
        edc     = 5'd28;
        is_ctrl = 1'b1;
      end
      default: e6_bad = 1'b1;
    endcase
    case (four)
      4'b1011, 4'b0100: fgh = 3'd0;
      // K28 swaps the meaning of these codes when its six-bit part runs positive
      4'b1001: fgh = (is_ctrl && six[5]) ? 3'd6 : 3'd1;
      4'b0110: fgh = (is_ctrl && six[5]) ? 3'd1 : 3'd6;
      4'b0101: fgh = (is_ctrl && six[5]) ? 3'd5 : 3'd2;
      4'b1010: fgh = (is_ctrl && six[5]) ? 3'd2 : 3'd5;
      4'b1100, 4'b0011: fgh = 3'd3;
      4'b1101, 4'b0010: fgh = 3'd4;
      4'b0111, 4'b1000: fgh = 3'd7;
      4'b1110, 4'b0001: fgh = 3'd7;
      default: e4_bad = 1'b1;
    endcase
    if (group == 10'b1110101000 || group == 10'b0001010111 ||
        group == 10'b1101101000 || group == 10'b0010010111 ||
        group == 10'b1011101000 || group == 10'b0100010111 ||
        group == 10'b0111101000 || group == 10'b1000010111)
    begin
      is_ctrl = 1'b1;
    end
    for (int i = 0; i < 10; i++)
    begin
      ones = ones + int'(group[i]);
    end
    byte_out = {fgh, edc};
    code_err = e6_bad | e4_bad;
    disp_err = (ones != 5) && (ones != 4) && (ones != 6);
  end
endmodule // scf_dec8b10b
`default_nettype wire

// ### scf_formatter_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module scf_formatter_monitor
#(
  parameter int OUT_W = 16
)
(
  input wire logic             clock,
  input wire logic             rst,
  input wire logic [2:0]       mode,
  input wire logic             mute,
  input wire logic             bit_in,
  input wire logic             bit_valid,
  input wire logic [OUT_W-1:0] dma_word,
  input wire logic             dma_valid
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_take2;
    bit_valid && !mute ##1 bit_valid && !mute;
  endsequence
  // Last two bits taken end up at the bottom of the word
  property p_tail(logic [2:0] m);
    s_take2 ##1 (dma_valid && mode == m) |-> dma_word[1:0] == {$past(bit_in, 2), $past(bit_in)};
  endproperty
  chk_one_pulse: assert property (dma_valid |=> !dma_valid)
    else $error("valid pulse too long");
  chk_valid_cause: assert property (dma_valid |-> $past(bit_valid && !mute))
    else $error("word without a taken bit");
  chk_word_hold: assert property (!dma_valid |-> $stable(dma_word))
    else $error("word moved without valid");
  chk_raw_tail: assert property (p_tail(scf_pkg::MODE_RAW))
    else $error("raw bit order wrong");
  chk_align_tail: assert property (p_tail(scf_pkg::MODE_ALIGNED))
    else $error("aligned bit order wrong");
  chk_rsvd_quiet: assert property ($past(mode) == scf_pkg::MODE_RSVD && mode == scf_pkg::MODE_RSVD |-> !dma_valid)
    else $error("reserved mode gave output");
  chk_align_zero: assert property (dma_valid && mode == scf_pkg::MODE_ALIGNED |-> dma_word[15:12] == 4'h0)
    else $error("aligned top bits not zero");
  chk_dec_zero: assert property (dma_valid && mode == scf_pkg::MODE_DECODED |-> dma_word[15:12] == 4'h0)
    else $error("decoded top bits not zero");
  chk_code_valid: assert property (dma_valid && mode == scf_pkg::MODE_DECODED |-> dma_word[11] == !(dma_word[9] || dma_word[10]))
    else $error("code valid flag wrong");
endmodule // scf_formatter_monitor
bind scf_formatter scf_formatter_monitor #(.OUT_W(OUT_W)) u_mon (.clock(clock), .rst(rst), .mode(mode), .mute(mute),
  .bit_in(bit_in), .bit_valid(bit_valid), .dma_word(dma_word), .dma_valid(dma_valid));
`default_nettype wire

// ### scf_dma_sink.sv
`timescale 1ns/10ps
`default_nettype none
module scf_dma_sink
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [15:0] dma_word,
  input wire logic        dma_valid
);
  logic [15:0] q[$];
  // Never stalls: the channel has no back-pressure
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      q.delete();
    else if (dma_valid === 1'b1)
      q.push_back(dma_word);
  end
endmodule // scf_dma_sink
`default_nettype wire

// ### scf_formatter_bench.sv
`timescale 1ns/10ps
`default_nettype none
module scf_formatter_bench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  mode = 3'h0;
  logic        cfg_drop_null = 1'b0;
  logic        mute = 1'b0;
  logic        bit_in = 1'b0;
  logic        bit_valid = 1'b0;
  logic        realign = 1'b0;
  logic [15:0] dma_word;
  logic        dma_valid, ts_locked, ts_long, hdr_tei, hdr_pusi;
  logic [12:0] hdr_pid;
  logic [1:0]  hdr_scramble, hdr_adapt;
  logic [3:0]  hdr_cc;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #2.5 clock = ~clock;
  scf_formatter uut (.clock(clock), .rst(rst), .mode(mode), .cfg_drop_null(cfg_drop_null), .mute(mute),
    .bit_in(bit_in), .bit_valid(bit_valid), .realign(realign), .dma_word(dma_word), .dma_valid(dma_valid),
    .ts_locked(ts_locked), .ts_long(ts_long), .hdr_tei(hdr_tei), .hdr_pusi(hdr_pusi), .hdr_pid(hdr_pid),
    .hdr_scramble(hdr_scramble), .hdr_adapt(hdr_adapt), .hdr_cc(hdr_cc));
  scf_dma_sink u_sink (.clock(clock), .rst(rst), .dma_word(dma_word), .dma_valid(dma_valid));
  task end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // First bit sent is the word's top bit
  task send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clock);
      bit_valid <= 1'b1;
      bit_in <= v[i];
    end
    @(posedge clock);
    bit_valid <= 1'b0;
  endtask
  // Realign each time so a left-over partial group cannot skew the next test
  task start(input logic [2:0] m, input logic drop);
    @(posedge clock);
    mode <= m;
    cfg_drop_null <= drop;
    realign <= 1'b1;
    u_sink.q.delete();
    @(posedge clock);
    realign <= 1'b0;
  endtask
  task pkt(input logic [7:0] h1, input logic [7:0] h2, input logic [7:0] h3);
    send(16'h0047, 8);
    send({8'h00, h1}, 8);
    send({8'h00, h2}, 8);
    send({8'h00, h3}, 8);
    repeat (184) send(16'h0000, 8);
  endtask
  task t_raw;
    start(scf_pkg::MODE_RAW, 1'b0);
    send(16'hA5C3, 16);
    send(16'h0F01, 16);
    @(posedge clock);
    mute <= 1'b1;
    send(16'hFFFF, 16);
    mute <= 1'b0;
    repeat (3) @(posedge clock);
    check(16'(u_sink.q.size()), 16'h0002);
    check(u_sink.q[0], 16'hA5C3);
    check(u_sink.q[1], 16'h0F01);
    $display("raw test done");
  endtask
  task t_align;
    start(scf_pkg::MODE_ALIGNED, 1'b0);
    send(16'h02B5, 10);
    send(16'h0155, 10);
    repeat (3) @(posedge clock);
    check(u_sink.q[0], 16'h06B5);
    check(u_sink.q[1], 16'h0155);
    $display("aligned test done");
  endtask
  task t_dec(input logic [2:0] m);
    start(m, 1'b0);
    send(16'h00FA, 10);
    send(16'h02AA, 10);
    send(16'h0000, 10);
    repeat (3) @(posedge clock);
    if (m == scf_pkg::MODE_DECODED)
    begin
      check(u_sink.q[0], 16'h09BC);
      check(u_sink.q[1], 16'h08B5);
      check(u_sink.q[2] & 16'hFE00, 16'h0600);
    end
    else
    begin
      check(16'(u_sink.q.size()), 16'h0001);
      check({8'h00, u_sink.q[0][7:0]}, 16'h00B5);
    end
    $display("decode test done");
  endtask
  task t_ts(input logic [2:0] m, input logic drop, input logic [15:0] n);
    start(m, drop);
    pkt(8'h81, 8'h23, 8'h95);
    repeat (3) @(posedge clock);
    check({3'h0, hdr_pid}, 16'h0123);
    check(16'({hdr_tei, hdr_pusi, hdr_scramble, hdr_adapt, hdr_cc}), 16'h0295);
    check(u_sink.q[0], 16'h0047);
    check(u_sink.q[1], 16'h0081);
    pkt(8'h1F, 8'hFF, 8'h10);
    send(16'h0047, 8);
    repeat (3) @(posedge clock);
    check({3'h0, hdr_pid}, 16'h1FFF);
    check(16'(u_sink.q.size()), n);
    $display("stream test done");
  endtask
  task t_ts_long;
    start(scf_pkg::MODE_TS, 1'b0);
    pkt(8'h01, 8'h00, 8'h00);
    repeat (16) send(16'h0000, 8);
    check({15'h0, ts_long}, 16'h0001);
    send(16'h0047, 8);
    repeat (3) @(posedge clock);
    check({14'h0, ts_locked, ts_long}, 16'h0002);
    check(16'(u_sink.q.size()), 16'h00CD);
    $display("long packet test done");
  endtask
  task t_test_modes;
    start(scf_pkg::MODE_PRBS, 1'b0);
    send(16'h0000, 16);
    send(16'h0000, 16);
    repeat (3) @(posedge clock);
    check(16'(u_sink.q.size()), 16'h0002);
    check({15'h0, u_sink.q[0] === 16'h0000}, 16'h0000);
    check({15'h0, u_sink.q[0] === u_sink.q[1]}, 16'h0000);
    start(scf_pkg::MODE_RSVD, 1'b0);
    send(16'hFFFF, 16);
    send(16'hFFFF, 16);
    repeat (3) @(posedge clock);
    check(16'(u_sink.q.size()), 16'h0000);
    $display("test mode test done");
  endtask
  // Stream runs dominate; the ceiling leaves about three times their length
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_raw();
    t_align();
    t_dec(scf_pkg::MODE_DECODED);
    t_dec(scf_pkg::MODE_DATA);
    t_ts(scf_pkg::MODE_TS, 1'b0, 16'd377);
    t_ts(scf_pkg::MODE_TS, 1'b1, 16'd193);
    t_ts(scf_pkg::MODE_TS_TIME, 1'b0, 16'd193);
    t_ts_long();
    t_test_modes();
    end_of_test();
  end
endmodule // scf_formatter_bench
`default_nettype wire
